// ### design/hbc_bridge_ctrl.sv
// bridge output control: input mapping, fault priority, current limit, open load
//
// Design decisions made here: register access over Wishbone and the register offsets.
`include "hbc_params.svh"
module hbc_bridge_ctrl
  import hbc_pkg::*;
#(
  parameter int BLANK_CYC   = `HBC_BLANK_CYC,
  parameter int BLANK_L_CYC = `HBC_BLANK_L_CYC,
  parameter int DISCH_CYC   = `HBC_DISCH_CYC,
  parameter int OLFILT_CYC  = `HBC_OLFILT_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // control pins
  input  wire logic        first_control_input_i,
  input  wire logic        second_control_input_i,
  input  wire logic        active_low_output_enable_pin_n_i,
  input  wire logic        output_shutoff_pin_i,
  // analog comparators, already filtered
  input  wire logic        current_limit_level_i,
  input  wire logic        overheat_i,
  input  wire logic        temp_warning_level_i,
  input  wire logic        ground_short_out_a_i,
  input  wire logic        ground_short_out_b_i,
  input  wire logic        supply_short_out_a_i,
  input  wire logic        supply_short_out_b_i,
  input  wire logic        supply_high_i,
  input  wire logic        supply_low_i,
  input  wire logic        out_a_above_ol_i,
  input  wire logic        flyback_overshoot_threshold_i,
  // gate drives and analog settings
  output logic             high_side_a_o,
  output logic             low_side_a_o,
  output logic             high_side_b_o,
  output logic             low_side_b_o,
  output logic             pull_up_a_o,
  output logic      [2:0]  slew_select_field_o,
  output logic      [1:0]  current_limit_sel_o
);
  hbc_state_t r;
  hbc_state_t next_r;

  logic hbr, idle, in_a, in_b, gate_off, acc, wr, do_clear;
  logic ot, scga, scgb, scpa, scpb, sc_a, sc_b;
  logic [9:0] set_f;
  logic [31:0] clr_mask, wmask;
  logic hs_a, ls_a, hs_b, ls_b, pull_a;

  always_comb begin
    next_r   = r;
    hbr      = r.ctrl[`HBC_C_HBR];
    idle     = r.ctrl[`HBC_C_IDLE];
    gate_off = r.ctrl[`HBC_C_GATE_OFF];
    // ----------------------------------------------------------------
    // input source
    // ----------------------------------------------------------------
    in_a = r.ctrl[`HBC_C_SERIAL] ? r.ctrl[`HBC_C_VIN_A] : first_control_input_i;
    in_b = r.ctrl[`HBC_C_SERIAL] ? r.ctrl[`HBC_C_VIN_B] : second_control_input_i;
    // ----------------------------------------------------------------
    // wishbone slave, one wait state
    // ----------------------------------------------------------------
    acc      = wb_cyc_i && wb_stb_i && !r.ack;
    wr       = acc && wb_we_i;
    next_r.ack = acc;
    wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    do_clear = wr && (wb_adr_i == `HBC_CLEAR_OFS);
    clr_mask = do_clear ? (wb_dat_i & wmask) : 32'h0000_0000;
    if (wr && wb_adr_i == `HBC_CTRL_OFS) begin
      next_r.ctrl = (r.ctrl & ~wmask) | (wb_dat_i & wmask & 32'h0000_377f);
    end
    next_r.dat = 32'h0000_0000;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        `HBC_CTRL_OFS:   next_r.dat = r.ctrl;
        `HBC_STATUS_OFS: next_r.dat = {19'h0, r.reg_st, r.ol_st != HBC_OL_IDLE,
                                       temp_warning_level_i, r.flags[8:0]};
        default:         next_r.dat = 32'h0000_0000;
      endcase
    end
    next_r.slew = r.ctrl[`HBC_C_SLEW_LO +: 3];
    next_r.current_limit_level = r.ctrl[`HBC_C_CURRENT_LIMIT_LEVEL_LO +: 2];
    // ----------------------------------------------------------------
    // fault flags: sticky, set wins over clear
    // ----------------------------------------------------------------
    set_f = '0;
    set_f[`HBC_S_OT]    = overheat_i;
    set_f[`HBC_S_SCG_A] = ground_short_out_a_i;
    set_f[`HBC_S_SCG_B] = ground_short_out_b_i;
    set_f[`HBC_S_SCP_A] = supply_short_out_a_i;
    set_f[`HBC_S_SCP_B] = supply_short_out_b_i;
    set_f[`HBC_S_OV]    = supply_high_i;
    set_f[`HBC_S_UV]    = supply_low_i;
    ot   = r.flags[`HBC_S_OT];
    scga = r.flags[`HBC_S_SCG_A];
    scgb = r.flags[`HBC_S_SCG_B];
    scpa = r.flags[`HBC_S_SCP_A];
    scpb = r.flags[`HBC_S_SCP_B];
    sc_a = scga || scpa;
    sc_b = scgb || scpb;
    // ----------------------------------------------------------------
    // current limit regulation, H-bridge only
    // ----------------------------------------------------------------
    // a turn-on edge is held back while current is above the limit
    next_r.pwm_eff = in_b && (r.pwm_eff || !current_limit_level_i);
    case (r.reg_st)
      HBC_REG_IDLE: begin
        if (current_limit_level_i && r.pwm_eff && hbr && !idle) begin
          next_r.reg_st  = HBC_REG_BLANK;
          set_f[`HBC_S_OC] = 1'b1;
          next_r.reg_cnt = temp_warning_level_i ? 18'(BLANK_L_CYC - 1)
                                                : 18'(BLANK_CYC - 1);
        end
      end
      HBC_REG_BLANK: begin
        if (r.reg_cnt == '0) begin
          next_r.reg_st = HBC_REG_DECAY;
          next_r.decay  = '0;
        end else begin
          next_r.reg_cnt = r.reg_cnt - 18'd1;
        end
      end
      HBC_REG_DECAY: begin
        if (!current_limit_level_i) begin
          next_r.reg_st  = HBC_REG_HOLD;
          next_r.reg_cnt = r.decay;
        end else if (r.decay != '1) begin
          next_r.decay = r.decay + 18'd1;
        end
      end
      HBC_REG_HOLD: begin
        if (r.reg_cnt == '0) begin
          next_r.reg_st = HBC_REG_IDLE;
        end else begin
          next_r.reg_cnt = r.reg_cnt - 18'd1;
        end
      end
      default: next_r.reg_st = HBC_REG_IDLE;
    endcase
    if (!in_b || !hbr || idle) begin
      next_r.reg_st = HBC_REG_IDLE;
    end
    // ----------------------------------------------------------------
    // standby open-load check
    // ----------------------------------------------------------------
    next_r.idle_q = idle;
    next_r.chk_q  = r.ctrl[`HBC_C_OLCHK];
    // one-cycle result pulse, so a later clear of the flag sticks
    next_r.ol_low_power_idle_mode = 1'b0;
    case (r.ol_st)
      HBC_OL_IDLE: begin
        if (hbr && r.ctrl[`HBC_C_OLCHK] &&
            ((r.idle_q && !idle) || (idle && !r.chk_q))) begin
          next_r.ol_st  = HBC_OL_DISCH;
          next_r.ol_cnt = 18'(DISCH_CYC - 1);
        end
      end
      HBC_OL_DISCH: begin
        if (r.ol_cnt == '0) begin
          next_r.ol_st  = HBC_OL_PULL;
          next_r.ol_cnt = 18'(OLFILT_CYC - 1);
        end else begin
          next_r.ol_cnt = r.ol_cnt - 18'd1;
        end
      end
      HBC_OL_PULL: begin
        if (r.ol_cnt == '0) begin
          next_r.ol_low_power_idle_mode = out_a_above_ol_i;
          next_r.ol_st   = HBC_OL_IDLE;
        end else begin
          next_r.ol_cnt = r.ol_cnt - 18'd1;
        end
      end
      default: next_r.ol_st = HBC_OL_IDLE;
    endcase
    if (!hbr || sc_a || sc_b) begin
      next_r.ol_st = HBC_OL_IDLE;
    end
    // ----------------------------------------------------------------
    // active open load: window is the PWM on phase
    // ----------------------------------------------------------------
    if (r.pwm_eff && flyback_overshoot_threshold_i) begin
      next_r.win_seen = 1'b1;
    end
    if (r.pwm_eff && !next_r.pwm_eff) begin
      next_r.ol_act   = !(r.win_seen || flyback_overshoot_threshold_i);
      next_r.win_seen = 1'b0;
    end
    if (idle || !hbr) begin
      next_r.ol_act   = 1'b0;
      next_r.win_seen = 1'b0;
    end
    set_f[`HBC_S_OL] = r.ol_low_power_idle_mode || r.ol_act;
    next_r.flags = (r.flags & ~clr_mask[9:0]) | set_f;
    // ----------------------------------------------------------------
    // commanded output, then priority overrides
    // ----------------------------------------------------------------
    hs_a   = 1'b0;
    ls_a   = 1'b0;
    hs_b   = 1'b0;
    ls_b   = 1'b0;
    pull_a = 1'b0;
    if (hbr) begin
      // PWM off recirculates through both low sides
      hs_a = r.pwm_eff && in_a;
      ls_a = !(r.pwm_eff && in_a);
      hs_b = r.pwm_eff && !in_a;
      ls_b = !(r.pwm_eff && !in_a);
      if (r.reg_st == HBC_REG_DECAY || r.reg_st == HBC_REG_HOLD) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b1010;
      end
      if (idle) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0000;
      end
      if (r.ol_st == HBC_OL_DISCH) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0101;
      end
      if (r.ol_st == HBC_OL_PULL) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0001;
        pull_a = 1'b1;
      end
      if (scpa || scpb) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0000;
        pull_a = 1'b0;
      end
      if (supply_high_i && !idle) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b1010;
        pull_a = 1'b0;
      end
      if (ot || scga || scgb || supply_low_i || gate_off ||
          !active_low_output_enable_pin_n_i || output_shutoff_pin_i) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0000;
        pull_a = 1'b0;
      end
    end else if (!idle) begin
      hs_a = in_a;
      ls_a = !in_a;
      hs_b = in_b;
      ls_b = !in_b;
      if (sc_a) begin
        {hs_a, ls_a} = 2'b00;
      end
      if (sc_b) begin
        {hs_b, ls_b} = 2'b00;
      end
      if (ot || gate_off || supply_low_i ||
          !active_low_output_enable_pin_n_i || output_shutoff_pin_i) begin
        {hs_a, ls_a, hs_b, ls_b} = 4'b0000;
      end
    end
    next_r.hs_a   = hs_a;
    next_r.ls_a   = ls_a && !hs_a;
    next_r.hs_b   = hs_b;
    next_r.ls_b   = ls_b && !hs_b;
    next_r.pull_a = pull_a;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r         <= '0;
      r.ctrl    <= `HBC_CTRL_RST;
      r.idle_q  <= 1'b1;
      // matches the check bit in the reset value: no check starts on reset
      r.chk_q   <= 1'b1;
      r.slew    <= 3'h4;
      r.current_limit_level    <= 2'h1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o            = r.dat;
  assign wb_ack_o            = r.ack;
  assign high_side_a_o       = r.hs_a;
  assign low_side_a_o        = r.ls_a;
  assign high_side_b_o       = r.hs_b;
  assign low_side_b_o        = r.ls_b;
  assign pull_up_a_o         = r.pull_a;
  assign slew_select_field_o = r.slew;
  assign current_limit_sel_o = r.current_limit_level;
endmodule

// ### design/hbc_params.svh
// constants for the bridge output control block
`ifndef HBC_PARAMS_SVH
`define HBC_PARAMS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define HBC_CTRL_OFS    4'h0
`define HBC_STATUS_OFS  4'h4
`define HBC_CLEAR_OFS   4'h8
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define HBC_C_HBR       0
`define HBC_C_SERIAL    1
`define HBC_C_VIN_A     2
`define HBC_C_VIN_B     3
`define HBC_C_GATE_OFF  4
`define HBC_C_OLCHK     5
`define HBC_C_IDLE      6
`define HBC_C_SLEW_LO   8
`define HBC_C_CURRENT_LIMIT_LEVEL_LO   12
`define HBC_CTRL_RST    32'h0000_1461
// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define HBC_S_OT        0
`define HBC_S_OC        1
`define HBC_S_SCG_A     2
`define HBC_S_SCG_B     3
`define HBC_S_SCP_A     4
`define HBC_S_SCP_B     5
`define HBC_S_OV        6
`define HBC_S_UV        7
`define HBC_S_OL        8
`define HBC_S_TW        9
`define HBC_S_OLBUSY    10
`define HBC_S_REG_LO    11
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HBC_CLK_NS      8
`define HBC_BLANK_NS    32000
`define HBC_BLANK_L_NS  256000
`define HBC_DISCH_NS    10000
`define HBC_OLFILT_NS   10000
`define HBC_BLANK_CYC   ((`HBC_BLANK_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_BLANK_L_CYC ((`HBC_BLANK_L_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_DISCH_CYC   ((`HBC_DISCH_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_OLFILT_CYC  ((`HBC_OLFILT_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`endif

// ### design/hbc_pkg.sv
// types for the bridge output control block
package hbc_pkg;
  // current limit regulation, gray along blank, decay, hold
  typedef enum logic [1:0] {
    HBC_REG_IDLE  = 2'b00,
    HBC_REG_BLANK = 2'b01,
    HBC_REG_DECAY = 2'b11,
    HBC_REG_HOLD  = 2'b10
  } hbc_reg_t;
  // standby open-load check
  typedef enum logic [1:0] {
    HBC_OL_IDLE  = 2'b00,
    HBC_OL_DISCH = 2'b01,
    HBC_OL_PULL  = 2'b11
  } hbc_ol_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [9:0]  flags;
    logic        ack;
    logic [31:0] dat;
    hbc_reg_t    reg_st;
    logic [17:0] reg_cnt;
    logic [17:0] decay;
    hbc_ol_t     ol_st;
    logic [17:0] ol_cnt;
    logic        pwm_eff;
    logic        win_seen;
    logic        ol_act;
    logic        ol_low_power_idle_mode;
    logic        idle_q;
    logic        chk_q;
    logic        hs_a;
    logic        ls_a;
    logic        hs_b;
    logic        ls_b;
    logic        pull_a;
    logic [2:0]  slew;
    logic [1:0]  current_limit_level;
  } hbc_state_t;
endpackage

// ### tb/hbc_bridge_ctrl_properties.sv
// assertions on the ports of the bridge output control block
module hbc_bridge_ctrl_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and gates
  input wire logic        active_low_output_enable_pin_n_i,
  input wire logic        output_shutoff_pin_i,
  input wire logic        ground_short_out_a_i,
  input wire logic        high_side_a_o,
  input wire logic        low_side_a_o,
  input wire logic        high_side_b_o,
  input wire logic        low_side_b_o,
  input wire logic        pull_up_a_o,
  input wire logic [2:0]  slew_select_field_o,
  input wire logic [1:0]  current_limit_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic wr_ctrl;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i == 4'hf;
  leg_a_safe_a: assert property (
    !(high_side_a_o && low_side_a_o)) else $error("leg a both on");
  leg_b_safe_a: assert property (
    !(high_side_b_o && low_side_b_o)) else $error("leg b both on");
  ack_answer_a: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack missing or too long");
  unmapped_zero_a: assert property (
    req && !wb_we_i && wb_adr_i == 4'hc |=> wb_dat_o == 32'h0) else $error("unmapped read");
  enable_off_a: assert property (
    !active_low_output_enable_pin_n_i |=> !high_side_a_o && !high_side_b_o)
    else $error("enable pin ignored");
  shutoff_off_a: assert property (
    output_shutoff_pin_i |=> !high_side_a_o && !high_side_b_o) else $error("shutoff ignored");
  slew_follow_a: assert property (
    wr_ctrl |-> ##2 slew_select_field_o == $past(wb_dat_i[10:8], 2)) else $error("slew copy");
  current_limit_level_follow_a: assert property (
    wr_ctrl |-> ##2 current_limit_sel_o == $past(wb_dat_i[13:12], 2)) else $error("current_limit_level copy");
  pull_stage_a: assert property (
    pull_up_a_o |-> low_side_b_o && !low_side_a_o && !high_side_a_o && !high_side_b_o)
    else $error("pull stage gates");
  short_off_a: assert property (
    ground_short_out_a_i |-> ##2 !high_side_a_o && !low_side_a_o) else $error("short ignored");
  cover property (pull_up_a_o);
  cover property (high_side_a_o && high_side_b_o);
  cover property ($fell(pull_up_a_o));
endmodule
bind hbc_bridge_ctrl hbc_bridge_ctrl_properties hbc_bridge_ctrl_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .active_low_output_enable_pin_n_i(active_low_output_enable_pin_n_i),
  .output_shutoff_pin_i(output_shutoff_pin_i), .ground_short_out_a_i(ground_short_out_a_i),
  .high_side_a_o(high_side_a_o), .low_side_a_o(low_side_a_o),
  .high_side_b_o(high_side_b_o), .low_side_b_o(low_side_b_o), .pull_up_a_o(pull_up_a_o),
  .slew_select_field_o(slew_select_field_o), .current_limit_sel_o(current_limit_sel_o)
);

// ### tb/hbc_bridge_ctrl_tb.sv
// self-checking bench for the bridge output control block
`include "hbc_params.svh"
module hbc_bridge_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic        lim = 1'b0;
  logic        tw = 1'b0;
  logic        gsa = 1'b0;
  logic        ola = 1'b1;
  logic [6:0]  ana = 7'h0;
  logic        in1, in2, en_n, off, hsa, lsa, hsb, lsb, pua;
  logic [2:0]  slew;
  logic [1:0]  current_limit_level;
  int          fails = 0;
  int          checks = 0;
  always #4 clk_i = ~clk_i;
  hbc_mcu_model hbc_mcu_model_inst (.clk_i(clk_i), .first_control_input_o(in1),
    .second_control_input_o(in2), .enable_n_o(en_n), .shutoff_o(off));
  hbc_bridge_ctrl #(.BLANK_CYC(8), .BLANK_L_CYC(64), .DISCH_CYC(4), .OLFILT_CYC(4))
  hbc_bridge_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .first_control_input_i(in1), .second_control_input_i(in2),
    .active_low_output_enable_pin_n_i(en_n), .output_shutoff_pin_i(off),
    .current_limit_level_i(lim), .overheat_i(ana[0]), .temp_warning_level_i(tw),
    .ground_short_out_a_i(gsa), .ground_short_out_b_i(ana[1]), .supply_short_out_a_i(ana[2]),
    .supply_short_out_b_i(ana[3]), .supply_high_i(ana[4]), .supply_low_i(ana[5]),
    .out_a_above_ol_i(ola), .flyback_overshoot_threshold_i(ana[6]), .high_side_a_o(hsa),
    .low_side_a_o(lsa), .high_side_b_o(hsb), .low_side_b_o(lsb), .pull_up_a_o(pua),
    .slew_select_field_o(slew), .current_limit_sel_o(current_limit_level));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    check("ack", n < 20, 1'b1);
  endtask
  function automatic logic [3:0] g();
    return {hsa, lsa, hsb, lsb};
  endfunction
  task automatic t_reset();
    check("slew", slew, 3'h4);
    check("current_limit_level", current_limit_level, 2'h1);
    wb(0, `HBC_CTRL_OFS, 0);
    check("ctrl", rdat, `HBC_CTRL_RST);
    wb(1, 4'hc, 32'hffff_ffff);
    wb(0, 4'hc, 0);
    check("unmapped", rdat, 0);
    for (int k = 0; k < 8; k++) begin
      wb(1, `HBC_CTRL_OFS, 32'h40 | (k << 8) | (k << 12));
      tick(2);
      check("slew", slew, k[2:0]);
      check("current_limit_level", current_limit_level, k[1:0]);
    end
  endtask
  task automatic t_map(input logic [31:0] mode);
    logic [3:0] e;
    for (int k = 0; k < 4; k++) begin
      wb(1, `HBC_CTRL_OFS, mode | (k << 2));
      hbc_mcu_model_inst.drive(k[0] ^ mode[1], k[1] ^ mode[1], 1'b1, 1'b0);
      tick(3);
      e = mode[0] ? (k[1] ? (k[0] ? 4'b1001 : 4'b0110) : 4'b0101)
                  : {k[0], !k[0], k[1], !k[1]};
      check("gates", g(), e);
    end
  endtask
  task automatic t_disable();
    wb(1, `HBC_CTRL_OFS, 32'h401);
    hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b0, 1'b0);
    tick(3);
    check("enable", g(), 0);
    hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b0, 1'b1);
    tick(3);
    check("enable over shutoff", g(), 0);
    hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b1, 1'b1);
    tick(3);
    check("shutoff", g(), 0);
    wb(1, `HBC_CTRL_OFS, 32'h411);
    hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b1, 1'b0);
    tick(3);
    check("gate off", g(), 0);
    wb(1, `HBC_CTRL_OFS, 32'h401);
    tick(3);
    check("restored", g(), 4'b1001);
  endtask
  task automatic t_limit(input logic warn, input int blank);
    wb(1, `HBC_CLEAR_OFS, 32'h1ff);
    @(posedge clk_i);
    lim <= 1'b1;
    tw <= warn;
    tick(blank / 2);
    check("blanking", g(), 4'b1001);
    tick(blank);
    check("recirc", g(), 4'b1010);
    if (!warn) begin
      hbc_mcu_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b0);
      tick(3);
      check("off at once", g(), 4'b0101);
      hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b1, 1'b0);
      tick(3);
      check("held off", g(), 4'b0101);
    end
    tick(8);
    lim <= 1'b0;
    tw <= 1'b0;
    tick(4);
    if (warn) check("recirc hold", g(), 4'b1010);
    tick(blank + 20);
    check("released", g(), 4'b1001);
    wb(0, `HBC_STATUS_OFS, 0);
    check("oc flag", rdat[1], 1'b1);
  endtask
  task automatic t_short();
    @(posedge clk_i);
    gsa <= 1'b1;
    @(posedge clk_i);
    gsa <= 1'b0;
    tick(4);
    check("short off", g(), 0);
    wb(0, `HBC_STATUS_OFS, 0);
    check("short flag", rdat[2], 1'b1);
    wb(1, `HBC_CLEAR_OFS, 32'h4);
    tick(3);
    check("short cleared", g(), 4'b1001);
  endtask
  task automatic t_standby();
    int n;
    logic saw;
    saw = 1'b0;
    n = 0;
    hbc_mcu_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b0);
    wb(1, `HBC_CTRL_OFS, 32'h441);
    wb(1, `HBC_CLEAR_OFS, 32'h100);
    wb(0, `HBC_STATUS_OFS, 0);
    check("ol before", rdat[8], 1'b0);
    wb(1, `HBC_CTRL_OFS, 32'h461);
    while (pua !== 1'b1 && n < 40) begin
      saw = saw | (g() == 4'b0101);
      @(posedge clk_i);
      n++;
    end
    check("discharge", saw, 1'b1);
    check("pull stage", {pua, g()}, 5'b10001);
    while (pua === 1'b1 && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    tick(2);
    check("returned", g(), 0);
    wb(0, `HBC_STATUS_OFS, 0);
    check("open load", rdat[8], 1'b1);
    wb(1, `HBC_CLEAR_OFS, 32'h100);
    ola <= 1'b0;
    wb(1, `HBC_CTRL_OFS, 32'h441);
    wb(1, `HBC_CTRL_OFS, 32'h461);
    tick(20);
    wb(0, `HBC_STATUS_OFS, 0);
    check("load present", rdat[8], 1'b0);
  endtask
  // pwm windows without, with and without overshoot, the last one never closing
  task automatic t_active_ol();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      ana[6] <= (k == 1);
      hbc_mcu_model_inst.drive(1'b1, 1'b1, 1'b1, 1'b0);
      tick(6);
      if (k == 1) wb(1, `HBC_CLEAR_OFS, 32'h100);
      wb(0, `HBC_STATUS_OFS, 0);
      check("ol held", rdat[8], k != 2);
      hbc_mcu_model_inst.drive(1'b1, k == 2, 1'b1, 1'b0);
      tick(3);
      wb(1, `HBC_CLEAR_OFS, 32'h100);
      wb(0, `HBC_STATUS_OFS, 0);
      check("ol window", rdat[8], k == 0);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    fails++;
    give_verdict();
  end
  initial begin
    tick(2);
    rst_i <= 1'b0;
    t_reset();
    t_map(32'h400);
    t_map(32'h402);
    t_map(32'h401);
    t_map(32'h403);
    t_disable();
    t_limit(1'b0, 8);
    t_limit(1'b1, 64);
    t_short();
    t_active_ol();
    t_standby();
    give_verdict();
  end
endmodule

// ### tb/hbc_mcu_model.sv
// controller side model: drives the control pins of the bridge block
module hbc_mcu_model (
  // clock
  input  wire logic clk_i,
  // control pins
  output logic      first_control_input_o,
  output logic      second_control_input_o,
  output logic      enable_n_o,
  output logic      shutoff_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    first_control_input_o = 1'b0;
    second_control_input_o = 1'b0;
    enable_n_o = 1'b1;
    shutoff_o = 1'b0;
  end
  // direction on the first pin, pwm on the second
  task automatic drive(input logic dir, input logic pwm, input logic en_n, input logic off);
    @(posedge clk_i);
    first_control_input_o <= dir;
    second_control_input_o <= pwm;
    enable_n_o <= en_n;
    shutoff_o <= off;
  endtask
endmodule
